//--- dcdc_pkg.sv
package dcdc_pkg;

    localparam logic [7:0] OFF_DESC = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h20;
    localparam logic [7:0] OFF_CHAN = 8'h24;
    localparam logic [7:0] OFF_STAT = 8'h28;
    localparam logic [7:0] OFF_IEN = 8'h2C;
    localparam logic [7:0] OFF_START = 8'h30;
    localparam logic [7:0] OFF_ERR = 8'h34;

    // descriptor word indices
    localparam logic [2:0] D_SADDR = 3'h0;
    localparam logic [2:0] D_DADDR = 3'h1;
    localparam logic [2:0] D_CNT = 3'h2;
    localparam logic [2:0] D_SLAST = 3'h3;
    localparam logic [2:0] D_DLAST = 3'h4;
    localparam logic [2:0] D_ITER = 3'h5;
    localparam logic [2:0] D_CTL = 3'h6;
    localparam logic [2:0] D_OFF = 3'h7;
    localparam logic [2:0] D_LAST = 3'h7;

    localparam int CTL_SRCM = 0;
    localparam int CTL_DMOD = 8;
    localparam int CTL_SG = 16;
    localparam int CTL_AUTO = 17;
    localparam int NB_SMLOE = 31;
    localparam int NB_DMLOE = 30;
    localparam int NB_MLOFF = 10;
    localparam int NB_CNT_W = 10;
    localparam int CTRL_MLM = 0;
    localparam int CTRL_CANCEL = 1;
    localparam int CH_REQ = 0;
    localparam int CH_ASYNC = 1;
    localparam int ST_ERR = 0;
    localparam int ST_DONE = 1;
    localparam int ST_HALF = 2;
    localparam int IEN_MASK = 4;

    localparam int E_DBE = 0;
    localparam int E_SBE = 1;
    localparam int E_SGE = 2;
    localparam int E_NCE = 3;
    localparam int E_DOE = 4;
    localparam int E_DAE = 5;
    localparam int E_SOE = 6;
    localparam int E_SAE = 7;
    localparam int E_CHN = 8;
    localparam int E_CPE = 14;
    localparam int E_ECX = 16;
    localparam int E_VLD = 31;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] XFER_BYTES = 32'h0000_0004;
    localparam int SG_ALIGN_BITS = 5;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } dcdc_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dcdc_axil_rsp_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dcdc_mem_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dcdc_mem_rsp_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CHECK = 3'h1,
        S_RD = 3'h2,
        S_WR = 3'h3,
        S_MINOR = 3'h4,
        S_MAJOR = 3'h5,
        S_SG = 3'h6
    } dcdc_state_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a <= OFF_ERR) && (a[1:0] == 2'h0);
    endfunction : addr_ok

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            apply_strb[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    endfunction : apply_strb

endpackage : dcdc_pkg

//--- dcdc_addr_step.sv
`timescale 1ns/1ps
module dcdc_addr_step (
    input wire logic [31:0] addr_i,
    input wire logic [31:0] inc_i,
    input wire logic [4:0] mod_i,
    input wire logic wrap_i,
    output logic [31:0] next_o
);
    logic [31:0] sum;
    logic [31:0] mask;

    // upper bits frozen: queue wraps to base
    always_comb
    begin
        sum = addr_i + inc_i;
        mask = (32'h0000_0001 << mod_i) - 32'h0000_0001;
        if (wrap_i && mod_i != 5'h00)
            next_o = (addr_i & ~mask) | (sum & mask);
        else
            next_o = sum;
    end
endmodule : dcdc_addr_step

//--- dcdc_axil_slave.sv
`timescale 1ns/1ps
module dcdc_axil_slave (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire dcdc_pkg::dcdc_axil_req_t req_i,
    output dcdc_pkg::dcdc_axil_rsp_t rsp_o,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    output logic [7:0] rd_addr_o,
    input wire logic [31:0] rd_data_i
);
    logic aw_full;
    logic w_full;
    logic [7:0] aw_q;

    assign rd_addr_o = req_i.araddr;

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_q <= 8'h00;
            wr_en_o <= 1'b0;
            wr_addr_o <= 8'h00;
            wr_data_o <= 32'h0000_0000;
            wr_strb_o <= 4'h0;
            rsp_o <= '0;
            rsp_o.awready <= 1'b1;
            rsp_o.wready <= 1'b1;
            rsp_o.arready <= 1'b1;
        end
        else
        begin
            wr_en_o <= 1'b0;
            if (req_i.awvalid && rsp_o.awready)
            begin
                aw_full <= 1'b1;
                aw_q <= req_i.awaddr;
                rsp_o.awready <= 1'b0;
            end
            if (req_i.wvalid && rsp_o.wready)
            begin
                w_full <= 1'b1;
                wr_data_o <= req_i.wdata;
                wr_strb_o <= req_i.wstrb;
                rsp_o.wready <= 1'b0;
            end
            if (aw_full && w_full && !rsp_o.bvalid)
            begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                wr_en_o <= dcdc_pkg::addr_ok(aw_q);
                wr_addr_o <= aw_q;
                rsp_o.bvalid <= 1'b1;
                rsp_o.bresp <= dcdc_pkg::addr_ok(aw_q) ?
                    dcdc_pkg::RESP_OKAY : dcdc_pkg::RESP_SLVERR;
            end
            // both address and data were taken before a response exists
            if (rsp_o.bvalid && req_i.bready)
            begin
                rsp_o.bvalid <= 1'b0;
                rsp_o.awready <= 1'b1;
                rsp_o.wready <= 1'b1;
            end
            if (req_i.arvalid && rsp_o.arready)
            begin
                rsp_o.arready <= 1'b0;
                rsp_o.rvalid <= 1'b1;
                rsp_o.rdata <= dcdc_pkg::addr_ok(req_i.araddr) ?
                    rd_data_i : 32'h0000_0000;
                rsp_o.rresp <= dcdc_pkg::addr_ok(req_i.araddr) ?
                    dcdc_pkg::RESP_OKAY : dcdc_pkg::RESP_SLVERR;
            end
            if (rsp_o.rvalid && req_i.rready)
            begin
                rsp_o.rvalid <= 1'b0;
                rsp_o.arready <= 1'b1;
            end
        end
    end
endmodule : dcdc_axil_slave

//--- dcdc_top.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - separate source and destination wrap ranges
// - modulo keeps low bits moving, upper frozen
// - stop mode needs async enable AND request enable
// - auto disable clears request enable at end
// - signed final adjusts added at major end
// - hardware requests served only while enabled
// - software start runs one minor loop
// - remaining major count readable from descriptor
// - byte count reads live decrementing value
// - status flags readable, cleared by mask
// - engine error word holds last error cause
// - interrupt enables set or cleared by mask
// - minor offsets only with mapping enable set
// - destination adjust doubles as chain pointer
// - whole descriptor writable through registers
// - half and full completion raise interrupts
// - major end reloads count, applies adjusts
// - error word splits causes, sets valid bit
module dcdc_top (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire dcdc_pkg::dcdc_axil_req_t axil_req_i,
    output dcdc_pkg::dcdc_axil_rsp_t axil_rsp_o,
    output dcdc_pkg::dcdc_mem_req_t mem_req_o,
    input wire dcdc_pkg::dcdc_mem_rsp_t mem_rsp_i,
    input wire logic hw_req_i,
    input wire logic stop_mode_i,
    output logic irq_o
);
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    logic [31:0] desc [8];
    logic mlm_en;
    logic cancel_pend;
    logic req_en;
    logic asy_en;
    logic [2:0] stat;
    logic [2:0] ien;
    logic [31:0] err_word;
    logic sw_pend;
    logic req_s1;
    logic req_s2;
    logic stop_s1;
    logic stop_s2;

    dcdc_pkg::dcdc_state_t state;
    logic [31:0] nb_init;
    logic [31:0] sg_base;
    logic [2:0] sg_cnt;

    logic ack;
    logic go;
    logic accept_hw;
    logic [31:0] next_err;
    logic err_hit;
    logic [31:0] nb_cnt;
    logic [31:0] nb_next;
    logic last_xfer;
    logic [15:0] cur;
    logic [15:0] beg;
    logic [15:0] cur_m1;
    logic sg_en;
    logic [19:0] mloff;
    logic [31:0] src_inc;
    logic [31:0] dst_inc;
    logic [31:0] src_next;
    logic [31:0] dst_next;
    logic xfer_wrap;
    logic done_set;
    logic half_set;

    dcdc_axil_slave u_slave (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .req_i(axil_req_i),
        .rsp_o(axil_rsp_o),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );

    dcdc_addr_step u_src (
        .addr_i(desc[dcdc_pkg::D_SADDR]),
        .inc_i(src_inc),
        .mod_i(desc[dcdc_pkg::D_CTL][dcdc_pkg::CTL_SRCM +: 5]),
        .wrap_i(xfer_wrap),
        .next_o(src_next)
    );

    dcdc_addr_step u_dst (
        .addr_i(desc[dcdc_pkg::D_DADDR]),
        .inc_i(dst_inc),
        .mod_i(desc[dcdc_pkg::D_CTL][dcdc_pkg::CTL_DMOD +: 5]),
        .wrap_i(xfer_wrap),
        .next_o(dst_next)
    );

    // async pins: two flops
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            stop_s1 <= 1'b0;
            stop_s2 <= 1'b0;
        end
        else
        begin
            req_s1 <= hw_req_i;
            req_s2 <= req_s1;
            stop_s1 <= stop_mode_i;
            stop_s2 <= stop_s1;
        end
    end

    assign cur = desc[dcdc_pkg::D_ITER][15:0];
    assign beg = desc[dcdc_pkg::D_ITER][31:16];
    assign cur_m1 = cur - 16'h0001;
    assign sg_en = desc[dcdc_pkg::D_CTL][dcdc_pkg::CTL_SG];
    assign mloff = desc[dcdc_pkg::D_CNT][dcdc_pkg::NB_MLOFF +: 20];
    assign ack = mem_req_o.valid && mem_rsp_i.ack;
    assign xfer_wrap = (state == dcdc_pkg::S_WR);
    assign accept_hw = req_s2 && req_en
        && (!stop_s2 || asy_en);
    assign go = (state == dcdc_pkg::S_IDLE) && (sw_pend || accept_hw);

    // mapping on: low field counts
    always_comb
    begin
        if (mlm_en)
        begin
            nb_cnt = {22'h0, desc[dcdc_pkg::D_CNT][9:0]};
            nb_next = {desc[dcdc_pkg::D_CNT][31:10],
                desc[dcdc_pkg::D_CNT][9:0] - 10'h004};
        end
        else
        begin
            nb_cnt = desc[dcdc_pkg::D_CNT];
            nb_next = desc[dcdc_pkg::D_CNT] - dcdc_pkg::XFER_BYTES;
        end
        last_xfer = (nb_cnt <= dcdc_pkg::XFER_BYTES);
    end

    always_comb
    begin
        src_inc = 32'h0000_0000;
        dst_inc = 32'h0000_0000;
        unique case (state)
            dcdc_pkg::S_WR:
            begin
                src_inc = {{16{desc[dcdc_pkg::D_OFF][15]}},
                    desc[dcdc_pkg::D_OFF][15:0]};
                dst_inc = {{16{desc[dcdc_pkg::D_OFF][31]}},
                    desc[dcdc_pkg::D_OFF][31:16]};
            end
            dcdc_pkg::S_MINOR:
            begin
                if (mlm_en && desc[dcdc_pkg::D_CNT][dcdc_pkg::NB_SMLOE])
                    src_inc = {{12{mloff[19]}}, mloff};
                if (mlm_en && desc[dcdc_pkg::D_CNT][dcdc_pkg::NB_DMLOE])
                    dst_inc = {{12{mloff[19]}}, mloff};
            end
            dcdc_pkg::S_MAJOR:
            begin
                src_inc = desc[dcdc_pkg::D_SLAST];
                dst_inc = desc[dcdc_pkg::D_DLAST];
            end
            default:
            begin
                src_inc = 32'h0000_0000;
                dst_inc = 32'h0000_0000;
            end
        endcase
    end

    // error causes for the current cycle
    always_comb
    begin
        next_err = 32'h0000_0000;
        if (state == dcdc_pkg::S_CHECK)
        begin
            next_err[dcdc_pkg::E_NCE] = (nb_cnt == 32'h0) || (cur == 16'h0)
                || (nb_cnt[1:0] != 2'h0);
            next_err[dcdc_pkg::E_SAE] = desc[dcdc_pkg::D_SADDR][1:0] != 2'h0;
            next_err[dcdc_pkg::E_SOE] = desc[dcdc_pkg::D_OFF][1:0] != 2'h0;
            next_err[dcdc_pkg::E_DAE] = desc[dcdc_pkg::D_DADDR][1:0] != 2'h0;
            next_err[dcdc_pkg::E_DOE] = desc[dcdc_pkg::D_OFF][17:16] != 2'h0;
        end
        if (ack && mem_rsp_i.err && state != dcdc_pkg::S_WR)
            next_err[dcdc_pkg::E_SBE] = 1'b1;
        if (ack && mem_rsp_i.err && state == dcdc_pkg::S_WR)
            next_err[dcdc_pkg::E_DBE] = 1'b1;
        if (ack && !mem_rsp_i.err && state == dcdc_pkg::S_WR && cancel_pend)
            next_err[dcdc_pkg::E_ECX] = 1'b1;
        if (state == dcdc_pkg::S_MAJOR && sg_en && desc[dcdc_pkg::D_DLAST]
            [dcdc_pkg::SG_ALIGN_BITS-1:0] != 5'h00)
            next_err[dcdc_pkg::E_SGE] = 1'b1;
        err_hit = (next_err != 32'h0000_0000);
    end

    assign done_set = (state == dcdc_pkg::S_MINOR) && (cur_m1 == 16'h0);
    assign half_set = (state == dcdc_pkg::S_MINOR) && (beg[15:1] != 15'h0)
        && (cur_m1 == {1'b0, beg[15:1]});

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= dcdc_pkg::S_IDLE;
            mem_req_o <= '0;
            nb_init <= dcdc_pkg::RST_WORD;
            sg_base <= dcdc_pkg::RST_WORD;
            sg_cnt <= 3'h0;
        end
        else
        begin
            unique case (state)
                dcdc_pkg::S_IDLE:
                    if (go)
                    begin
                        state <= dcdc_pkg::S_CHECK;
                        nb_init <= desc[dcdc_pkg::D_CNT];
                    end
                dcdc_pkg::S_CHECK:
                    if (err_hit)
                        state <= dcdc_pkg::S_IDLE;
                    else
                    begin
                        state <= dcdc_pkg::S_RD;
                        mem_req_o <= {1'b1, 1'b0, desc[dcdc_pkg::D_SADDR],
                            32'h0000_0000};
                    end
                dcdc_pkg::S_RD:
                    if (ack)
                    begin
                        if (err_hit)
                        begin
                            state <= dcdc_pkg::S_IDLE;
                            mem_req_o.valid <= 1'b0;
                        end
                        else
                        begin
                            state <= dcdc_pkg::S_WR;
                            mem_req_o <= {1'b1, 1'b1, desc[dcdc_pkg::D_DADDR],
                                mem_rsp_i.rdata};
                        end
                    end
                dcdc_pkg::S_WR:
                    if (ack)
                    begin
                        if (err_hit || last_xfer)
                        begin
                            state <= err_hit ? dcdc_pkg::S_IDLE
                                : dcdc_pkg::S_MINOR;
                            mem_req_o.valid <= 1'b0;
                        end
                        else
                        begin
                            state <= dcdc_pkg::S_RD;
                            mem_req_o <= {1'b1, 1'b0, src_next, 32'h0000_0000};
                        end
                    end
                dcdc_pkg::S_MINOR:
                    state <= done_set ? dcdc_pkg::S_MAJOR : dcdc_pkg::S_IDLE;
                dcdc_pkg::S_MAJOR:
                    if (sg_en && !err_hit)
                    begin
                        state <= dcdc_pkg::S_SG;
                        sg_base <= desc[dcdc_pkg::D_DLAST];
                        sg_cnt <= 3'h0;
                        mem_req_o <= {1'b1, 1'b0, desc[dcdc_pkg::D_DLAST],
                            32'h0000_0000};
                    end
                    else
                        state <= dcdc_pkg::S_IDLE;
                dcdc_pkg::S_SG:
                    if (ack)
                    begin
                        if (err_hit || sg_cnt == dcdc_pkg::D_LAST)
                        begin
                            state <= dcdc_pkg::S_IDLE;
                            mem_req_o.valid <= 1'b0;
                        end
                        else
                        begin
                            sg_cnt <= sg_cnt + 3'h1;
                            mem_req_o.addr <= sg_base
                                + {27'h0, sg_cnt + 3'h1, 2'h0};
                        end
                    end
                default:
                    state <= dcdc_pkg::S_IDLE;
            endcase
        end
    end

    // engine update beats bus write
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < 8; i++)
                desc[i] <= dcdc_pkg::RST_WORD;
        end
        else
        begin
            if (wr_en && wr_addr < dcdc_pkg::OFF_CTRL)
                desc[wr_addr[4:2]] <= dcdc_pkg::apply_strb(desc[wr_addr[4:2]],
                    wr_data, wr_strb);
            if (state == dcdc_pkg::S_WR && ack && !mem_rsp_i.err)
            begin
                desc[dcdc_pkg::D_SADDR] <= src_next;
                desc[dcdc_pkg::D_DADDR] <= dst_next;
                desc[dcdc_pkg::D_CNT] <= nb_next;
            end
            if (state == dcdc_pkg::S_MINOR)
            begin
                desc[dcdc_pkg::D_SADDR] <= src_next;
                desc[dcdc_pkg::D_DADDR] <= dst_next;
                desc[dcdc_pkg::D_CNT] <= nb_init;
                desc[dcdc_pkg::D_ITER][15:0] <= cur_m1;
            end
            if (state == dcdc_pkg::S_MAJOR)
            begin
                desc[dcdc_pkg::D_SADDR] <= src_next;
                if (!sg_en)
                    desc[dcdc_pkg::D_DADDR] <= dst_next;
                desc[dcdc_pkg::D_ITER][15:0] <= beg;
            end
            if (state == dcdc_pkg::S_SG && ack && !mem_rsp_i.err)
                desc[sg_cnt] <= mem_rsp_i.rdata;
        end
    end

    // control and channel enables
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mlm_en <= 1'b0;
            cancel_pend <= 1'b0;
            req_en <= 1'b0;
            asy_en <= 1'b0;
            sw_pend <= 1'b0;
            ien <= 3'h0;
        end
        else
        begin
            if (wr_en && wr_addr == dcdc_pkg::OFF_CTRL && wr_strb[0])
                mlm_en <= wr_data[dcdc_pkg::CTRL_MLM];
            if (state == dcdc_pkg::S_IDLE || state == dcdc_pkg::S_WR && ack)
                cancel_pend <= 1'b0;
            if (wr_en && wr_addr == dcdc_pkg::OFF_CTRL && wr_strb[0]
                && wr_data[dcdc_pkg::CTRL_CANCEL] && state != dcdc_pkg::S_IDLE)
                cancel_pend <= 1'b1;
            if (state == dcdc_pkg::S_MAJOR
                && desc[dcdc_pkg::D_CTL][dcdc_pkg::CTL_AUTO])
                req_en <= 1'b0;
            // software write beats auto clear
            if (wr_en && wr_addr == dcdc_pkg::OFF_CHAN && wr_strb[0])
            begin
                req_en <= wr_data[dcdc_pkg::CH_REQ];
                asy_en <= wr_data[dcdc_pkg::CH_ASYNC];
            end
            if (go)
                sw_pend <= 1'b0;
            if (wr_en && wr_addr == dcdc_pkg::OFF_START && wr_strb[0]
                && wr_data[0])
                sw_pend <= 1'b1;
            if (wr_en && wr_addr == dcdc_pkg::OFF_IEN && wr_strb[0])
                ien <= (ien & ~wr_data[dcdc_pkg::IEN_MASK +: 3])
                    | (wr_data[2:0] & wr_data[dcdc_pkg::IEN_MASK +: 3]);
        end
    end

    // sticky: new event beats clear
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            stat <= 3'h0;
            err_word <= dcdc_pkg::RST_WORD;
            irq_o <= 1'b0;
        end
        else
        begin
            if (wr_en && wr_addr == dcdc_pkg::OFF_STAT && wr_strb[0])
                stat <= (stat & ~wr_data[2:0]) | {half_set, done_set, err_hit};
            else
                stat <= stat | {half_set, done_set, err_hit};
            if (err_hit)
            begin
                err_word <= next_err;
                err_word[dcdc_pkg::E_VLD] <= 1'b1;
            end
            irq_o <= |(stat & ien);
        end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (rd_addr < dcdc_pkg::OFF_CTRL)
            rd_data = desc[rd_addr[4:2]];
        else
        begin
            unique case (rd_addr)
                dcdc_pkg::OFF_CTRL: rd_data = {31'h0, mlm_en};
                dcdc_pkg::OFF_CHAN: rd_data = {30'h0, asy_en, req_en};
                dcdc_pkg::OFF_STAT: rd_data = {29'h0, stat};
                dcdc_pkg::OFF_IEN: rd_data = {29'h0, ien};
                dcdc_pkg::OFF_ERR: rd_data = err_word;
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end
endmodule : dcdc_top

//--- dcdc_mem_model.sv
`timescale 1ns/1ps
module dcdc_mem_model (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire dcdc_pkg::dcdc_mem_req_t req_i,
    output dcdc_pkg::dcdc_mem_rsp_t rsp_o,
    output logic [31:0] waddr_o
);
    logic [1:0] wait_q;
    always_ff @(posedge clock_i or negedge nrst_i)
        if (!nrst_i)
        begin
            rsp_o <= '0;
            wait_q <= 2'h0;
            waddr_o <= 32'h0;
        end
        else if (req_i.valid && !rsp_o.ack && wait_q == req_i.addr[3:2])
        begin
            rsp_o <= {1'b1, 1'b0, req_i.addr ^ 32'hA5A5_0000};
            wait_q <= 2'h0;
            if (req_i.we)
                waddr_o <= req_i.addr;
        end
        else
        begin
            rsp_o <= {1'b0, 1'b0, ~rsp_o.rdata};
            wait_q <= wait_q + {1'b0, req_i.valid};
        end
endmodule : dcdc_mem_model

//--- dcdc_monitor.sv
`timescale 1ns/1ps
module dcdc_monitor (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire dcdc_pkg::dcdc_axil_req_t axil_req_i,
    input wire dcdc_pkg::dcdc_axil_rsp_t axil_rsp_o,
    input wire dcdc_pkg::dcdc_mem_req_t mem_req_o,
    input wire dcdc_pkg::dcdc_mem_rsp_t mem_rsp_i,
    input wire logic irq_o
);
    logic [2:0] since;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence word_read;
        mem_req_o.valid && !mem_req_o.we && mem_rsp_i.ack;
    endsequence : word_read
    always_ff @(posedge clock_i or negedge nrst_i)
        if (!nrst_i)
            since <= 3'h7;
        else if (mem_rsp_i.ack || axil_rsp_o.bvalid)
            since <= 3'h0;
        else if (since != 3'h7)
            since <= since + 3'h1;
    a_read_answer: assert property (
        axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid)
        else $error("read answer missing");
    a_write_answer: assert property (
        axil_req_i.awvalid && axil_rsp_o.awready && axil_req_i.wvalid &&
        axil_rsp_o.wready |=> ##1 axil_rsp_o.bvalid)
        else $error("no write answer");
    a_bad_addr: assert property (
        axil_req_i.arvalid && axil_rsp_o.arready && axil_req_i.araddr > 8'h34
        |=> axil_rsp_o.rresp == 2'h2 && axil_rsp_o.rdata == 32'h0)
        else $error("unmapped read accepted");
    a_mem_hold: assert property (
        mem_req_o.valid && !mem_rsp_i.ack |=> mem_req_o.valid &&
        $stable(mem_req_o.addr)) else $error("memory request dropped");
    a_copy_word: assert property (
        word_read ##1 mem_req_o.we |-> mem_req_o.wdata ==
        $past(mem_rsp_i.rdata)) else $error("written word differs");
    a_read_first: assert property (
        $rose(mem_req_o.valid) |-> !mem_req_o.we)
        else $error("transfer began with a write");
    a_irq_rise: assert property (
        $rose(irq_o) |-> since < 3'h6) else $error("irq rose without cause");
    a_irq_fall: assert property (
        $fell(irq_o) |-> since < 3'h6) else $error("irq fell without write");
endmodule : dcdc_monitor
bind dcdc_top dcdc_monitor i_mon (.clock_i(clock_i), .nrst_i(nrst_i),
    .axil_req_i(axil_req_i), .axil_rsp_o(axil_rsp_o), .mem_req_o(mem_req_o),
    .mem_rsp_i(mem_rsp_i), .irq_o(irq_o));

//--- test_dcdc_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_dcdc_top;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hw_req = 1'b0;
    logic stop_mode = 1'b0;
    logic irq;
    logic [31:0] waddr;
    logic [31:0] seed = 32'h0000_9FDB;
    logic [31:0] v;
    logic [33:0] got_e;
    logic [33:0] exp_q[$];
    logic [31:0] prog [8] = '{32'h100, 32'h200, 32'h4, 32'hFFFF_FFF8, 32'h10,
        32'h0002_0002, 32'h0002_0000, 32'h0004_0004};
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    dcdc_pkg::dcdc_axil_req_t req = '0;
    dcdc_pkg::dcdc_axil_rsp_t rsp;
    dcdc_pkg::dcdc_mem_req_t mreq;
    dcdc_pkg::dcdc_mem_rsp_t mrsp;
    dcdc_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .axil_req_i(req),
        .axil_rsp_o(rsp), .mem_req_o(mreq), .mem_rsp_i(mrsp),
        .hw_req_i(hw_req), .stop_mode_i(stop_mode), .irq_o(irq));
    dcdc_mem_model i_mem (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(mreq),
        .rsp_o(mrsp), .waddr_o(waddr));
    initial forever #4 clock_i = ~clock_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic stop_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        dcdc_pkg::dcdc_axil_rsp_t hs;
        if (!w)
            exp_q.push_back({a > dcdc_pkg::OFF_ERR, 1'b0, d});
        @(posedge clock_i);
        req <= {a, w, d, 4'hF, w, w, a, !w, !w};
        do
        begin
            @(negedge clock_i);
            hs = rsp;
            @(posedge clock_i);
            if (hs.awready)
                req.awvalid <= 1'b0;
            if (hs.wready)
                req.wvalid <= 1'b0;
            if (hs.arready)
                req.arvalid <= 1'b0;
        end
        while (!(hs.bvalid && w) && !(hs.rvalid && !w));
        req.bready <= 1'b0;
        req.rready <= 1'b0;
    endtask : bus
    task automatic kick(input logic h);
        hw_req <= h;
        @(posedge clock_i);
        hw_req <= 1'b0;
        repeat (40) @(posedge clock_i);
    endtask : kick
    always @(negedge clock_i)
    begin
        cyc++;
        if (rsp.rvalid && req.rready)
        begin
            got_e = exp_q.pop_front();
            `CHK({rsp.rresp, rsp.rdata}, got_e)
        end
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            v = (k == 6) ? seed & 32'h0003_1F1F : seed;
            bus(1, 8'(k * 4), v);
            bus(0, 8'(k * 4), v);
        end
        foreach (prog[k])
            bus(1, 8'(k * 4), prog[k]);
        bus(1, 8'h2C, 32'h72);
        kick(1);
        bus(0, 8'h14, 32'h0002_0002);
        bus(1, 8'h24, 32'h1);
        kick(1);
        bus(0, 8'h14, 32'h0002_0001);
        bus(0, 8'h28, 32'h4);
        `CHK(irq, 1'b0)
        kick(1);
        bus(0, 8'h00, 32'h100);
        bus(0, 8'h04, 32'h218);
        bus(0, 8'h14, 32'h0002_0002);
        bus(0, 8'h24, 32'h0);
        `CHK(waddr, 32'h204)
        `CHK(irq, 1'b1)
        bus(1, 8'h28, 32'h6);
        bus(0, 8'h28, 32'h0);
        `CHK(irq, 1'b0)
        stop_mode <= 1'b1;
        bus(1, 8'h24, 32'h1);
        kick(1);
        bus(0, 8'h14, 32'h0002_0002);
        bus(1, 8'h24, 32'h3);
        kick(1);
        bus(0, 8'h14, 32'h0002_0001);
        bus(1, 8'h30, 32'h1);
        kick(0);
        bus(0, 8'h14, 32'h0002_0002);
        `CHK(waddr, 32'h21C)
        bus(0, 8'h38, 32'h0);
        bus(0, 8'h34, 32'h0);
        @(posedge clock_i);
        stop_test();
    end
endmodule : test_dcdc_top
